/* sim/acr_regs_props.sv */
// Port-level properties of the ADC mode and output registers
`timescale 1ns/10ps
`default_nettype none
module acr_regs_props (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Observed ports
  input wire logic spi_cs_n_i,
  input wire logic spi_sdo_oe_n_o,
  input wire logic pll_en_i,
  input wire logic dll_en_i,
  input wire logic ref_clk_on_o,
  input wire logic core_on_o,
  input wire logic restart_o,
  input wire logic clk_dist_on_o,
  input wire logic cal_start_o,
  input wire logic pll_cal_start_o,
  input wire logic dll_reset_o,
  input wire logic [3:0] channel_count_o,
  input wire logic data_valid_o
);
  // One domain, so one clock and one disable
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  a_sdo_release: assert property (spi_cs_n_i [*6] |-> spi_sdo_oe_n_o)
    else $error("sdo driven while deselected");
  a_cal_single: assert property (cal_start_o |=> !cal_start_o)
    else $error("calibration start longer than one cycle");
  a_pll_with_cal: assert property (pll_cal_start_o |-> cal_start_o)
    else $error("pll calibration without calibration start");
  a_pll_quiet: assert property (!pll_en_i [*3] |-> !pll_cal_start_o)
    else $error("pll calibration while pll disabled");
  a_dll_with_cal: assert property (dll_reset_o |-> cal_start_o)
    else $error("dll reset without calibration start");
  a_dll_quiet: assert property (!dll_en_i [*3] |-> !dll_reset_o)
    else $error("dll reset while dll disabled");
  a_restart_dist: assert property (restart_o |-> !clk_dist_on_o && !cal_start_o)
    else $error("clocks or calibration during restart");
  a_restart_quiet: assert property (restart_o [*3] |-> !data_valid_o)
    else $error("output word during restart");
  a_off_dark: assert property (!ref_clk_on_o |-> !core_on_o && !clk_dist_on_o)
    else $error("core alive with reference off");
  a_idle_quiet: assert property (!core_on_o [*3] |-> !data_valid_o)
    else $error("output word with core off");
  a_chan_range: assert property (channel_count_o inside {[4'h1:4'h8]})
    else $error("channel count out of range");
  // Main scenarios reached
  c_cal: cover property (cal_start_o);
  c_read: cover property (!spi_sdo_oe_n_o);
  c_word: cover property (data_valid_o);
  c_restart: cover property (restart_o);
endmodule : acr_regs_props
bind acr_regs acr_regs_props u_acr_regs_props (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
  .spi_cs_n_i(spi_cs_n_i), .spi_sdo_oe_n_o(spi_sdo_oe_n_o), .pll_en_i(pll_en_i),
  .dll_en_i(dll_en_i), .ref_clk_on_o(ref_clk_on_o), .core_on_o(core_on_o), .restart_o(restart_o),
  .clk_dist_on_o(clk_dist_on_o), .cal_start_o(cal_start_o), .pll_cal_start_o(pll_cal_start_o),
  .dll_reset_o(dll_reset_o), .channel_count_o(channel_count_o), .data_valid_o(data_valid_o));
`default_nettype wire

/* sim/acr_spi_host.sv */
// Serial host model that configures the ADC register block
`timescale 1ns/10ps
`default_nettype none
module acr_spi_host (
  // System clock
  input wire logic clk_sys_i,
  // Serial port as seen from the host
  output logic spi_sclk_o,
  output logic spi_cs_n_o,
  output logic spi_sdi_o,
  input wire logic spi_sdo_i,
  input wire logic spi_sdo_oe_n_i
);
  // Cycles per serial clock phase; the port needs four, six leave margin for the synchroniser
  localparam int PH = 6;
  // Host view of the device bit order and read launch edge
  logic lsb_first = 1'b0;
  logic fall_edge = 1'b1;
  // Idle pins: clock low, deselected
  initial
  begin
    spi_sclk_o = 1'b0;
    spi_cs_n_o = 1'b1;
    spi_sdi_o = 1'b0;
  end
  // Waits leave on a falling edge, away from the sampling edge
  task automatic wt(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask : wt
  // A released data line floats, so it reads as the inverse
  task automatic take(input int j, inout logic [7:0] d);
    d[lsb_first ? j : 7 - j] = spi_sdo_oe_n_i ? ~spi_sdo_i : spi_sdo_i;
  endtask : take
  // One whole frame: command byte then data byte, order per bit-order flag
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] wd, output logic [7:0] q);
    logic [15:0] f;
    f = {rd, a, wd};
    q = 8'h00;
    wt(1);
    spi_cs_n_o = 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      spi_sdi_o = f[(1 - i / 8) * 8 + (lsb_first ? i % 8 : 7 - i % 8)];
      wt(PH);
      // Falling launch: bit j sampled just before rise 9+j
      if (fall_edge && i >= 8)
        take(i - 8, q);
      spi_sclk_o = 1'b1;
      wt(PH);
      // Rising launch: bit j sampled late in the high phase of rise 8+j
      if (!fall_edge && i >= 7 && i < 15)
        take(i - 7, q);
      spi_sclk_o = 1'b0;
    end
    wt(PH);
    spi_cs_n_o = 1'b1;
    spi_sdi_o = ~spi_sdi_o;
    wt(PH);
  endtask : xfer
endmodule : acr_spi_host
`default_nettype wire

/* sim/tb.sv */
// Self-checking bench for the ADC mode and output registers
`timescale 1ns/10ps
`default_nettype none
module tb;
  import acr_pkg::*;
  // Clock, reset and pins
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic sclk, cs_n, sdi, sdo, sdo_oe_n, adc_valid = 1'b0, pll_en = 1'b1, dll_en = 1'b0;
  logic [15:0] adc_data = 16'h1235;
  logic [7:0] dly = 8'h03;
  // Design outputs
  logic ref_on, core_on, rst_o, dist_on, cal, pllc, dllr, dval, output_data_clock, fclk, pdclk, pfclk, prst, fsave;
  logic [3:0] chan;
  logic [15:0] dout, exp_d;
  logic [7:0] rd;
  // Counters of the run and of the monitor
  int n_errors = 0, tests_run = 0, cyc = 0, n_val, n_output_data_clock, n_frm, n_bad, t_rel, t_cal, n_pll, n_dll;
  // Default map, one unmapped place included
  localparam logic [6:0] AD[6] = '{ACR_ADDR_MODE, ACR_ADDR_CHAN, ACR_ADDR_RATE, ACR_ADDR_SDO, ACR_ADDR_RAND, 7'h03};
  localparam logic [7:0] DF[6] = '{8'h24, 8'h0f, 8'h00, 8'h9f, 8'h62, 8'h00};
  always #25 clk_sys_i = ~clk_sys_i;
  acr_regs u_acr_regs (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(1'b1), .spi_sclk_i(sclk),
    .spi_cs_n_i(cs_n), .spi_sdi_i(sdi), .spi_sdo_o(sdo), .spi_sdo_oe_n_o(sdo_oe_n), .adc_data_i(adc_data),
    .adc_valid_i(adc_valid), .cal_delay_count_i(dly), .pll_en_i(pll_en), .dll_en_i(dll_en),
    .ref_clk_on_o(ref_on), .core_on_o(core_on), .restart_o(rst_o), .clk_dist_on_o(dist_on),
    .cal_start_o(cal), .pll_cal_start_o(pllc), .dll_reset_o(dllr), .channel_count_o(chan),
    .data_out_o(dout), .data_valid_o(dval), .output_data_clock_o(output_data_clock), .frame_clock_o(fclk));
  acr_spi_host host (.clk_sys_i(clk_sys_i), .spi_sclk_o(sclk), .spi_cs_n_o(cs_n), .spi_sdi_o(sdi),
    .spi_sdo_i(sdo), .spi_sdo_oe_n_i(sdo_oe_n));
  // Monitor: words, clock and frame toggles, restart release and launch times
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (dval === 1'b1 && dout !== exp_d)
      n_bad++;
    n_val += (dval === 1'b1);
    n_output_data_clock += (output_data_clock !== pdclk);
    n_frm += (fclk !== pfclk);
    if (prst === 1'b1 && rst_o === 1'b0)
      t_rel = cyc;
    if (cal === 1'b1)
      t_cal = cyc;
    n_pll += (pllc === 1'b1);
    n_dll += (dllr === 1'b1);
    {pdclk, pfclk, prst} = {output_data_clock, fclk, rst_o};
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask : wt
  // One comparison of design values
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rng(input int v, input int lo, input int hi);
    tests_run++;
    if (v < lo || v > hi)
    begin
      n_errors++;
      $display("FAIL %0t delay %0d outside %0d..%0d", $time, v, lo, hi);
    end
  endtask : rng
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.xfer(1'b0, a, d, rd);
  endtask : wr
  task automatic rchk(input logic [6:0] a, input logic [7:0] e);
    host.xfer(1'b1, a, 8'h00, rd);
    chk({8'h00, rd}, {8'h00, e});
  endtask : rchk
  // Reference on, core on, restart, clocks distributed
  task automatic pwr(input logic [3:0] e);
    chk({12'h000, ref_on, core_on, rst_o, dist_on}, {12'h000, e});
  endtask : pwr
  // 64 samples; 64 is a multiple of every tested ratio, so counts are phase free
  task automatic burst(input int e_val, input int e_clk);
    wt(8);
    {n_val, n_output_data_clock, n_frm, n_bad} = '0;
    repeat (64)
    begin
      adc_valid = 1'b1;
      wt(1);
      adc_valid = 1'b0;
      wt(1);
    end
    wt(8);
    if (e_val >= 0)
      rng(n_val, e_val, e_val);
    if (e_clk >= 0)
      rng(n_output_data_clock, e_clk, e_clk);
    rng(n_frm, n_val, n_val);
    rng(n_bad, 0, 0);
  endtask : burst
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  // Watchdog well beyond the expected 12k cycles
  initial
  begin
    #3000000;
    n_errors++;
    $display("FAIL %0t watchdog expired", $time);
    final_report();
  end
  // Main sequence; the test data codes are never written
  initial
  begin
    wt(8);
    rst_i = 1'b0;
    wt(2);
    foreach (AD[i]) rchk(AD[i], DF[i]);
    pwr(4'hd);
    wr(7'h03, 8'h5a);
    rchk(7'h03, 8'h00);
    for (int c = 0; c < 8; c++)
    begin
      wr(ACR_ADDR_CHAN, {2'b00, 3'(c), 3'b111});
      chk(16'(chan), (c == 0) ? 16'h0008 : 16'(c));
    end
    wr(ACR_ADDR_CHAN, ACR_RST_CHAN);
    exp_d = 16'h1235;
    burst(64, 64);
    wr(ACR_ADDR_RATE, 8'h30);
    burst(8, 8);
    wr(ACR_ADDR_RATE, 8'h60);
    burst(1, 1);
    wr(ACR_ADDR_CHAN, 8'h8f);
    wr(ACR_ADDR_RATE, 8'h0f);
    burst(64, 64);
    wr(ACR_ADDR_RATE, 8'h02);
    burst(64, 16);
    wr(ACR_ADDR_RATE, 8'h0e);
    burst(64, 0);
    wr(ACR_ADDR_RATE, 8'h00);
    burst(64, 0);
    wr(ACR_ADDR_CHAN, ACR_RST_CHAN);
    exp_d = 16'h0000;
    wr(ACR_ADDR_RATE, 8'hd0);
    burst(-1, -1);
    wr(ACR_ADDR_RATE, 8'h00);
    wr(ACR_ADDR_RAND, 8'h63);
    exp_d = 16'hedcb;
    burst(64, 64);
    fsave = fclk;
    wr(ACR_ADDR_RAND, 8'he2);
    chk({15'h0000, fclk}, {15'h0000, ~fsave});
    wr(ACR_ADDR_RAND, ACR_RST_RAND);
    wr(ACR_ADDR_MODE, 8'ha5);
    pwr(4'h0);
    burst(0, 0);
    rchk(ACR_ADDR_CHAN, ACR_RST_CHAN);
    wr(ACR_ADDR_MODE, 8'h00);
    pwr(4'he);
    burst(0, 0);
    t_cal = -1;
    n_pll = 0;
    n_dll = 0;
    wr(ACR_ADDR_MODE, 8'h24);
    wt(60);
    rng(t_cal - t_rel, 32, 34);
    rng(n_pll + 8 * n_dll, 1, 1);
    wr(ACR_ADDR_RAND, 8'h22);
    pll_en = 1'b0;
    dll_en = 1'b1;
    t_cal = -1;
    n_pll = 0;
    n_dll = 0;
    wr(ACR_ADDR_MODE, 8'h00);
    wr(ACR_ADDR_MODE, 8'h24);
    rng(t_cal - t_rel, 1, 3);
    rng(n_pll + 8 * n_dll, 8, 8);
    wr(ACR_ADDR_RAND, ACR_RST_RAND);
    wr(ACR_ADDR_MODE, 8'h3c);
    pwr(4'h9);
    burst(0, 0);
    wr(ACR_ADDR_MODE, 8'h00);
    wr(ACR_ADDR_MODE, 8'h04);
    pwr(4'hd);
    wr(ACR_ADDR_MODE, 8'h34);
    pwr(4'hd);
    wr(ACR_ADDR_MODE, 8'h20);
    pwr(4'he);
    wr(ACR_ADDR_MODE, 8'h66);
    host.lsb_first = 1'b1;
    rchk(ACR_ADDR_MODE, 8'h66);
    wr(ACR_ADDR_SDO, 8'h1f);
    host.fall_edge = 1'b0;
    rchk(ACR_ADDR_CHAN, ACR_RST_CHAN);
    wr(ACR_ADDR_SDO, ACR_RST_SDO);
    host.fall_edge = 1'b1;
    wr(ACR_ADDR_MODE, 8'h24);
    host.lsb_first = 1'b0;
    rchk(ACR_ADDR_MODE, 8'h24);
    final_report();
  end
endmodule : tb
`default_nettype wire

/* verilog/acr_pkg.sv */
// Constants and types shared by the ADC mode and output configuration registers
package acr_pkg;

  // Register addresses as seen in the serial command byte
  localparam logic [6:0] ACR_ADDR_MODE = 7'h00;
  localparam logic [6:0] ACR_ADDR_CHAN = 7'h01;
  localparam logic [6:0] ACR_ADDR_RATE = 7'h02;
  localparam logic [6:0] ACR_ADDR_SDO = 7'h04;
  localparam logic [6:0] ACR_ADDR_RAND = 7'h07;

  // Power-on values, factory bits included
  localparam logic [7:0] ACR_RST_MODE = 8'h24;
  localparam logic [7:0] ACR_RST_CHAN = 8'h0f;
  localparam logic [7:0] ACR_RST_RATE = 8'h00;
  localparam logic [7:0] ACR_RST_SDO = 8'h9f;
  localparam logic [7:0] ACR_RST_RAND = 8'h62;
  localparam logic [7:0] ACR_RD_NONE = 8'h00;

  // Mode register, lower nibble positions (upper nibble mirrors them)
  localparam int ACR_MODE_OFF_B = 0;
  localparam int ACR_MODE_LSB_B = 1;
  localparam int ACR_MODE_RUN_B = 2;
  localparam int ACR_MODE_IDLE_B = 3;

  // Field positions of the other registers
  localparam int ACR_IND_EN_B = 7;
  localparam int ACR_CHAN_LSB = 3;
  localparam int ACR_DRATE_LSB = 4;
  localparam int ACR_CRATE_LSB = 0;
  localparam int ACR_SDO_EDGE_B = 7;
  localparam int ACR_FRAME_INV_B = 7;
  localparam int ACR_CAL_DLY_B = 6;
  localparam int ACR_RAND_EN_B = 0;

  // Rate and channel codes
  localparam logic [3:0] ACR_DIV_MAX = 4'h9;
  localparam logic [3:0] ACR_ZERO_MIN = 4'hd;
  localparam logic [3:0] ACR_CLK_FULL = 4'hf;
  localparam logic [3:0] ACR_CODE_NONE = 4'h0;
  localparam logic [2:0] ACR_CHAN_EIGHT = 3'h0;
  localparam logic [3:0] ACR_EIGHT_INPUTS = 4'h8;

  // Serial frame layout: command byte then data byte
  localparam int ACR_SPI_RW_B = 7;
  localparam logic [4:0] ACR_CMD_BITS = 5'h08;
  localparam logic [4:0] ACR_FRAME_BITS = 5'h10;
  localparam logic [3:0] ACR_BYTE_BITS = 4'h8;

  // Calibration start delay: one step per code unit plus one
  localparam int ACR_CLK_PERIOD_NS = 50;
  localparam int ACR_CAL_STEP_NS = 400;
  localparam logic [11:0] ACR_CAL_STEP_CYC =
    12'((ACR_CAL_STEP_NS + ACR_CLK_PERIOD_NS - 1) / ACR_CLK_PERIOD_NS);

  // Calibration launch sequencer
  typedef enum logic [1:0]
  {
    ACR_CAL_IDLE = 2'b00,
    ACR_CAL_WAIT = 2'b01,
    ACR_CAL_FIRE = 2'b11
  } acr_cal_st_t;

endpackage : acr_pkg

/* verilog/acr_rdiv.sv */
// Power-of-two event divider: one tick every 2**code events
`timescale 1ns/10ps
`default_nettype none
module acr_rdiv (
  // Clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Events and divide code 0..9
  input wire logic evt_i,
  input wire logic [3:0] code_i,
  output logic tick_o
);

  logic [8:0] cnt_q; // Events seen since last tick
  logic [8:0] mask; // Terminal count, 2**code - 1

  // Terminal count from the code
  always_comb
  begin
    mask = 9'((10'h001 << code_i) - 10'h001);
    // At or past the terminal count: a code lowered mid-count must not wait for the 9-bit wrap
    tick_o = evt_i && (cnt_q >= mask);
  end

  // Count events, wrap on tick
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      cnt_q <= '0;
    else if (ce_i && evt_i)
    begin
      if (tick_o)
        cnt_q <= '0;
      else
        cnt_q <= cnt_q + 9'h001;
    end
  end

endmodule : acr_rdiv
`default_nettype wire

/* verilog/acr_regs.sv */
// Mode, channel, output rate and serial timing registers of a pipelined ADC
`timescale 1ns/10ps
`default_nettype none
module acr_regs
  import acr_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Serial port pins
  input wire logic spi_sclk_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_sdi_i,
  output logic spi_sdo_o,
  output logic spi_sdo_oe_n_o,
  // Converter samples
  input wire logic [15:0] adc_data_i,
  input wire logic adc_valid_i,
  // Settings held elsewhere
  input wire logic [7:0] cal_delay_count_i,
  input wire logic pll_en_i,
  input wire logic dll_en_i,
  // Power and restart state
  output logic ref_clk_on_o,
  output logic core_on_o,
  output logic restart_o,
  output logic clk_dist_on_o,
  // Calibration launch pulses
  output logic cal_start_o,
  output logic pll_cal_start_o,
  output logic dll_reset_o,
  // Channel selection
  output logic [3:0] channel_count_o,
  // Output data and clocks
  output logic [15:0] data_out_o,
  output logic data_valid_o,
  output logic output_data_clock_o,
  output logic frame_clock_o
);

  // Register storage
  logic [7:0] mode_q; // Power and bit order
  logic [7:0] chan_q; // Channel count
  logic [7:0] rate_q; // Output rates
  logic [7:0] sdo_q; // Serial-out timing
  logic [7:0] rand_q; // Randomizer and frame clock

  // Decoded controls
  logic power_off; // Shutdown
  logic lsb_first; // Serial bit order
  logic run_n; // Restart held when low
  logic idle; // Standby
  logic serial_out_edge; // 1: launch on falling edge
  logic independent_divider_en;
  logic [2:0] channel_count;
  logic [3:0] data_rate_div;
  logic [3:0] clock_rate_div;
  logic frame_clk_invert;
  logic cal_delay_en;
  logic rand_en;

  // Only the lower nibble is decoded; its mirror is storage only
  always_comb
  begin
    power_off = mode_q[ACR_MODE_OFF_B];
    lsb_first = mode_q[ACR_MODE_LSB_B];
    run_n = mode_q[ACR_MODE_RUN_B];
    idle = mode_q[ACR_MODE_IDLE_B];
    independent_divider_en = chan_q[ACR_IND_EN_B];
    channel_count = chan_q[ACR_CHAN_LSB +: 3];
    data_rate_div = rate_q[ACR_DRATE_LSB +: 4];
    clock_rate_div = rate_q[ACR_CRATE_LSB +: 4];
    serial_out_edge = sdo_q[ACR_SDO_EDGE_B];
    frame_clk_invert = rand_q[ACR_FRAME_INV_B];
    cal_delay_en = rand_q[ACR_CAL_DLY_B];
    rand_en = rand_q[ACR_RAND_EN_B];
  end

  // Serial pins into the system clock domain
  logic [2:0] pins_s; // {sclk, cs_n, sdi} after two flops
  acr_sync #(.W(3)) u_pin_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .async_i({spi_sclk_i, spi_cs_n_i, spi_sdi_i}),
    .sync_o(pins_s)
  );

  logic sclk_prev_q; // Previous synced clock for edges
  logic sclk_rise;
  logic sclk_fall;
  logic sel; // Chip selected

  // Edges are taken from the second stage only
  always_comb
  begin
    sel = !pins_s[1];
    sclk_rise = sel && pins_s[2] && !sclk_prev_q;
    sclk_fall = sel && !pins_s[2] && sclk_prev_q;
  end

  // Serial receive state
  logic [4:0] bit_cnt_q; // Rising edges in this frame
  logic [7:0] shift_q; // Receive shifter
  logic [7:0] shift_d;
  logic rd_q; // Frame is a read
  logic [6:0] addr_q; // Target register
  logic [7:0] tx_q; // Read data being sent
  logic [3:0] tx_cnt_q; // Bits already launched
  logic [7:0] rdata; // Read mux
  logic wr_en; // Data byte complete on a write
  logic hdr_done; // Command byte complete
  logic launch; // Drive next read bit

  // New shifter value per bit order; LSB first fills from the top
  always_comb
  begin
    if (lsb_first)
      shift_d = {pins_s[0], shift_q[7:1]};
    else
      shift_d = {shift_q[6:0], pins_s[0]};
    hdr_done = sclk_rise && (bit_cnt_q == ACR_CMD_BITS - 5'h01);
    wr_en = sclk_rise && !rd_q && (bit_cnt_q == ACR_FRAME_BITS - 5'h01);
  end

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    unique case (shift_d[6:0])
      ACR_ADDR_MODE: rdata = mode_q;
      ACR_ADDR_CHAN: rdata = chan_q;
      ACR_ADDR_RATE: rdata = rate_q;
      ACR_ADDR_SDO: rdata = sdo_q;
      ACR_ADDR_RAND: rdata = rand_q;
      default: rdata = ACR_RD_NONE;
    endcase
  end

  // Launch on the falling edge by default, else on rising edges past the header
  always_comb
  begin
    launch = rd_q && (tx_cnt_q < ACR_BYTE_BITS) && (bit_cnt_q >= ACR_CMD_BITS) &&
      (serial_out_edge ? sclk_fall : sclk_rise);
  end

  // Frame counting and command capture; deselect aborts a partial frame
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      sclk_prev_q <= 1'b0;
      bit_cnt_q <= '0;
      shift_q <= '0;
      rd_q <= 1'b0;
      addr_q <= '0;
    end
    else if (ce_i)
    begin
      sclk_prev_q <= pins_s[2];
      if (!sel)
      begin
        bit_cnt_q <= '0;
        rd_q <= 1'b0;
      end
      else if (sclk_rise)
      begin
        shift_q <= shift_d;
        if (bit_cnt_q < ACR_FRAME_BITS)
          bit_cnt_q <= bit_cnt_q + 5'h01;
        if (hdr_done)
        begin
          rd_q <= shift_d[ACR_SPI_RW_B];
          addr_q <= shift_d[6:0];
        end
      end
    end
  end

  // Read data launch and pin enable; the bit index follows the bit order
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      tx_q <= '0;
      tx_cnt_q <= '0;
      spi_sdo_o <= 1'b0;
      spi_sdo_oe_n_o <= 1'b1;
    end
    else if (ce_i)
    begin
      if (!sel)
      begin
        tx_cnt_q <= '0;
        spi_sdo_oe_n_o <= 1'b1;
      end
      else if (hdr_done && shift_d[ACR_SPI_RW_B])
      begin
        tx_q <= rdata;
        spi_sdo_oe_n_o <= 1'b0;
        // Rising-edge mode drives the first bit on the header's last edge
        if (!serial_out_edge)
        begin
          spi_sdo_o <= lsb_first ? rdata[0] : rdata[7];
          tx_cnt_q <= 4'h1;
        end
      end
      else if (launch)
      begin
        spi_sdo_o <= lsb_first ? tx_q[tx_cnt_q[2:0]] : tx_q[3'h7 - tx_cnt_q[2:0]];
        tx_cnt_q <= tx_cnt_q + 4'h1;
      end
    end
  end

  // Register writes; power modes never touch the stored values
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      mode_q <= ACR_RST_MODE;
      chan_q <= ACR_RST_CHAN;
      rate_q <= ACR_RST_RATE;
      sdo_q <= ACR_RST_SDO;
      rand_q <= ACR_RST_RAND;
    end
    else if (ce_i && wr_en)
    begin
      // Factory bits are stored as written; keeping them is the host's job
      unique case (addr_q)
        ACR_ADDR_MODE: mode_q <= shift_d;
        ACR_ADDR_CHAN: chan_q <= shift_d;
        ACR_ADDR_RATE: rate_q <= shift_d;
        ACR_ADDR_SDO: sdo_q <= shift_d;
        ACR_ADDR_RAND: rand_q <= shift_d;
        default: ; // Unmapped writes are dropped
      endcase
    end
  end

  // Power state outputs
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      ref_clk_on_o <= 1'b0;
      core_on_o <= 1'b0;
      restart_o <= 1'b0;
      clk_dist_on_o <= 1'b0;
      channel_count_o <= {1'b0, ACR_RST_CHAN[ACR_CHAN_LSB +: 3]};
    end
    else if (ce_i)
    begin
      ref_clk_on_o <= !power_off;
      core_on_o <= !power_off && !idle;
      restart_o <= !run_n;
      clk_dist_on_o <= !power_off && run_n;
      channel_count_o <= (channel_count == ACR_CHAN_EIGHT) ? ACR_EIGHT_INPUTS
        : {1'b0, channel_count};
    end
  end

  // Calibration launch after restart release
  acr_cal_st_t cal_st_q;
  logic run_prev_q; // Restart bit one cycle ago
  logic [11:0] wait_q; // Remaining delay cycles
  logic [11:0] wait_load; // Delay for the current setting

  // Delay grows linearly with the setting
  always_comb
  begin
    wait_load = 12'(({4'h0, cal_delay_count_i} + 12'h001) * ACR_CAL_STEP_CYC);
  end

  // Sequencer; a new restart aborts a pending launch
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      cal_st_q <= ACR_CAL_IDLE;
      run_prev_q <= 1'b1;
      wait_q <= '0;
      cal_start_o <= 1'b0;
      pll_cal_start_o <= 1'b0;
      dll_reset_o <= 1'b0;
    end
    else if (ce_i)
    begin
      run_prev_q <= run_n;
      cal_start_o <= 1'b0;
      pll_cal_start_o <= 1'b0;
      dll_reset_o <= 1'b0;
      if (!run_n)
        cal_st_q <= ACR_CAL_IDLE;
      else
      begin
        unique case (cal_st_q)
          ACR_CAL_IDLE:
          begin
            if (!run_prev_q)
            begin
              wait_q <= wait_load;
              cal_st_q <= cal_delay_en ? ACR_CAL_WAIT : ACR_CAL_FIRE;
            end
          end
          ACR_CAL_WAIT:
          begin
            if (wait_q <= 12'h001)
              cal_st_q <= ACR_CAL_FIRE;
            else
              wait_q <= wait_q - 12'h001;
          end
          ACR_CAL_FIRE:
          begin
            cal_start_o <= 1'b1;
            pll_cal_start_o <= pll_en_i;
            dll_reset_o <= dll_en_i;
            cal_st_q <= ACR_CAL_IDLE;
          end
          default: cal_st_q <= ACR_CAL_IDLE;
        endcase
      end
    end
  end

  // Output rate selection
  logic adc_run; // Converter producing words
  logic sample_evt;
  logic data_zero; // Forced all-zero codes
  logic data_ok; // Code is a divider or zero code
  logic [3:0] data_code;
  logic clk_on;
  logic [3:0] clk_code;
  logic data_tick;
  logic clk_tick;

  // Clock follows data rate unless the independent divider is on
  always_comb
  begin
    adc_run = !power_off && !idle && run_n;
    sample_evt = adc_valid_i && adc_run;
    data_zero = data_rate_div >= ACR_ZERO_MIN;
    data_ok = (data_rate_div <= ACR_DIV_MAX) || data_zero;
    data_code = (data_rate_div <= ACR_DIV_MAX) ? data_rate_div : ACR_CODE_NONE;
    if (independent_divider_en)
    begin
      clk_on = (clock_rate_div != ACR_CODE_NONE) &&
        ((clock_rate_div <= ACR_DIV_MAX) || (clock_rate_div == ACR_CLK_FULL));
      clk_code = (clock_rate_div == ACR_CLK_FULL) ? ACR_CODE_NONE : clock_rate_div;
    end
    else
    begin
      clk_on = data_ok;
      clk_code = data_code;
    end
  end

  acr_rdiv u_data_div (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .evt_i(sample_evt),
    .code_i(data_code),
    .tick_o(data_tick)
  );

  acr_rdiv u_clk_div (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .evt_i(sample_evt),
    .code_i(clk_code),
    .tick_o(clk_tick)
  );

  logic frame_base_q; // Uninverted frame clock

  // Output words; test codes leave the output unchanged and silent
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      data_out_o <= '0;
      data_valid_o <= 1'b0;
      frame_base_q <= 1'b0;
      frame_clock_o <= 1'b0;
      output_data_clock_o <= 1'b0;
    end
    else if (ce_i)
    begin
      data_valid_o <= data_tick && data_ok;
      if (data_tick && data_ok)
      begin
        frame_base_q <= !frame_base_q;
        frame_clock_o <= !frame_base_q ^ frame_clk_invert;
        if (data_zero)
          data_out_o <= '0;
        else if (rand_en)
          data_out_o <= {adc_data_i[15:1] ^ {15{adc_data_i[0]}}, adc_data_i[0]};
        else
          data_out_o <= adc_data_i;
      end
      else
        frame_clock_o <= frame_base_q ^ frame_clk_invert;
      // Clock pin parks low when no clock is selected or the core is stopped
      if (!clk_on || !adc_run)
        output_data_clock_o <= 1'b0;
      else if (clk_tick)
        output_data_clock_o <= !output_data_clock_o;
    end
  end

endmodule : acr_regs
`default_nettype wire

/* verilog/acr_sync.sv */
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/10ps
`default_nettype none
module acr_sync #(
  parameter int W = 1
) (
  // Clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Asynchronous in, synchronous out
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta_q; // First stage, read only by the second

  // Both stages clear on reset; chip select briefly reads selected, harmless while the clock pin idles low
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      meta_q <= '0;
      sync_o <= '0;
    end
    else if (ce_i)
    begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule : acr_sync
`default_nettype wire
